// ### design/tlr_pkg.sv
package tlr_pkg;
  // command opcodes presented on the command port
  localparam logic [3:0] TLR_OP_READ_UNTIL = 4'h1; // read_until_terminator
  localparam logic [3:0] TLR_OP_READ_PLUS1 = 4'h2; // read_terminator_plus_one
  localparam int         TLR_MAX_TIMER     = 9;     // highest accepted timer code
  localparam int         TLR_NUM_TERM      = 4;     // terminator list entries
  // line control block status byte values
  localparam logic [7:0] TLR_B2_DONE       = 8'h80;
  localparam logic [7:0] TLR_B2_REJECT     = 8'hC0;
  localparam logic [7:0] TLR_B3_BAD_CMD    = 8'hC2;
  localparam logic [7:0] TLR_B3_ZERO_CNT   = 8'hC4;
  localparam logic [7:0] TLR_B3_BAD_TIMER  = 8'hC6;
  localparam logic [7:0] TLR_B10_ABORT     = 8'h80;
  localparam logic [7:0] TLR_B10_TIMER     = 8'h40;
  localparam logic [7:0] TLR_B10_TERM      = 8'h20;
  localparam logic [7:0] TLR_B10_BCC       = 8'h08;
  localparam logic [7:0] TLR_B10_SW_OVR    = 8'h04;
  localparam logic [7:0] TLR_B10_TX_ERR    = 8'h02;
  localparam logic [7:0] TLR_B11_MODEM     = 8'h80;
  localparam logic [7:0] TLR_B11_DISC      = 8'h40;
  localparam logic [7:0] TLR_B11_HW_OVR    = 8'h04;
  localparam logic [7:0] TLR_B11_HW_TIMER  = 8'h02;
  localparam logic [7:0] TLR_ZERO_BYTE     = 8'h00;
  // line error vector bit positions (err_i)
  localparam int TLR_E_BCC = 0;
  localparam int TLR_E_SWO = 1;
  localparam int TLR_E_TXE = 2;
  localparam int TLR_E_MDM = 3;
  localparam int TLR_E_DSC = 4;
  localparam int TLR_E_HWO = 5;
  localparam int TLR_E_HWT = 6;
  localparam int TLR_E_W   = 7;
  typedef enum logic [2:0] {
    TLR_IDLE = 3'b001,
    TLR_RECV = 3'b010,
    TLR_PLUS = 3'b100
  } tlr_state_t;
endpackage

// ### design/tlr_term_match.sv
`timescale 1ns/1ps
// compares one received character against the terminator list
module tlr_term_match
  import tlr_pkg::*;
#(
  parameter int NT = TLR_NUM_TERM
) (
  input  wire logic [7:0]      char_i,   // received character
  input  wire logic [8*NT-1:0] list_i,   // terminator characters
  input  wire logic [NT-1:0]   valid_i,  // which entries are programmed
  output logic                 match_o   // any entry matches
);
  logic [NT-1:0] hit;
  // one comparator per list entry
  genvar g;
  for (g = 0; g < NT; g++) begin : g_cmp
    assign hit[g] = valid_i[g] && (list_i[8*g +: 8] == char_i);
  end
  assign match_o = |hit;
endmodule

// ### design/tlr_receive.sv
`timescale 1ns/1ps
// Contract
// - received characters are stored in order from the buffer start location
// - each received control character is compared to the terminator list
// - terminator match ends the whole command program, no chaining
// - plus-one variant stores exactly one more character after the terminator if the buffer has room left
// - count reaching buffer length with no terminator received ends this command, chain continues
// - synchronous mode strips pad characters arriving after a terminator, in the plus-one variant only
// - without a terminator, pad characters stay in the stored message
// - completion sets byte 2 to 80 (C0 on reject); stop and terminator ends mark cause in byte 10 or 11, full buffer end leaves both at 00
module tlr_receive
  import tlr_pkg::*;
#(
  parameter int AW = 16,   // storage address width
  parameter int CW = 16    // byte count width
) (
  input  wire logic                    mclk_i,       // 200 MHz clock
  input  wire logic                    sys_rst_i,    // async reset, high
  input  wire logic                    cmd_valid_i,  // command start pulse
  input  wire logic [3:0]              cmd_op_i,     // opcode
  input  wire logic [AW-1:0]           cmd_addr_i,   // buffer start location
  input  wire logic [CW-1:0]           cmd_len_i,    // buffer length
  input  wire logic [8*TLR_NUM_TERM-1:0] cmd_list_i, // terminator list
  input  wire logic [TLR_NUM_TERM-1:0] cmd_lvld_i,   // list entries in use
  input  wire logic [3:0]              cmd_timer_i,  // timer code
  input  wire logic                    cmd_chain_i,  // a command is chained
  input  wire logic                    sync_mode_i,  // synchronous line
  input  wire logic [7:0]              pad_char_i,   // pad character value
  input  wire logic                    rx_valid_i,   // received character strobe
  input  wire logic [7:0]              rx_char_i,    // received character
  input  wire logic                    rx_ctrl_i,    // character is control class
  input  wire logic                    abort_i,      // abort request
  input  wire logic                    timeout_i,    // command timer expired
  input  wire logic [TLR_E_W-1:0]      err_i,        // line error events
  output logic                         busy_o,       // command running
  output logic                         wr_en_o,      // storage write strobe
  output logic [AW-1:0]                wr_addr_o,    // storage address
  output logic [7:0]                   wr_data_o,    // storage data
  output logic                         done_o,       // completion pulse
  output logic                         chain_next_o, // continue with next command
  output logic [7:0]                   lcb_b2_o,     // line control block byte 2
  output logic [7:0]                   lcb_b3_o,     // line control block byte 3
  output logic [7:0]                   lcb_b10_o,    // line control block byte 10
  output logic [7:0]                   lcb_b11_o,    // line control block byte 11
  output logic [CW-1:0]                residual_o    // remaining byte count
);
  tlr_state_t state_q;
  logic [AW-1:0] addr_q;
  logic [CW-1:0] left_q;
  logic [8*TLR_NUM_TERM-1:0] list_q;
  logic [TLR_NUM_TERM-1:0]   lvld_q;
  logic chain_q, sync_q, plus_q;
  logic match;

  // plus-one variant flag, read by the sequencer
  function automatic logic op_plus();
    return plus_q;
  endfunction

  tlr_term_match #(.NT(TLR_NUM_TERM)) u_match (
    .char_i  (rx_char_i),
    .list_i  (list_q),
    .valid_i (lvld_q),
    .match_o (match)
  );

  // command checks; list of zero entries counts as an invalid command
  wire op_ok   = (cmd_op_i == TLR_OP_READ_UNTIL) || (cmd_op_i == TLR_OP_READ_PLUS1);
  wire list_ok = |cmd_lvld_i;
  wire tmr_ok  = (32'(cmd_timer_i) <= TLR_MAX_TIMER);
  wire accept  = cmd_valid_i && (state_q == TLR_IDLE) && op_ok && list_ok && tmr_ok &&
                 (cmd_len_i != '0);
  wire reject  = cmd_valid_i && (state_q == TLR_IDLE) && !accept;

  // terminator seen on a control character
  wire term_hit = (state_q == TLR_RECV) && rx_valid_i && rx_ctrl_i && match;
  // pads vanish only once a terminator is recognised in sync mode; the message
  // is not held back, so pads ahead of the terminator stay in the buffer, a
  // limitation of the no-buffer design
  wire term_pending = (state_q == TLR_PLUS);
  wire is_pad   = sync_q && (rx_char_i == pad_char_i) && !rx_ctrl_i;
  wire strip    = is_pad && term_pending;
  wire store    = rx_valid_i && (left_q != '0) && !strip &&
                  ((state_q == TLR_PLUS) || (state_q == TLR_RECV));
  wire full_end = store && (state_q == TLR_RECV) && (left_q == CW'(1)) && !term_hit;
  wire any_err  = |err_i;
  wire stop_ev  = (state_q != TLR_IDLE) && (abort_i || timeout_i || any_err);

  // sequence control
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= TLR_IDLE;
    end else begin
      case (state_q)
        TLR_IDLE: if (accept) state_q <= TLR_RECV;
        TLR_RECV: begin
          if (stop_ev || full_end) state_q <= TLR_IDLE;
          else if (term_hit) state_q <= op_plus() ? TLR_PLUS : TLR_IDLE;
        end
        TLR_PLUS: if (stop_ev || (rx_valid_i && !strip)) state_q <= TLR_IDLE;
        default: state_q <= TLR_IDLE;
      endcase
    end
  end

  // captured command fields
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      list_q <= '0;
      lvld_q <= '0;
      chain_q <= 1'b0;
      sync_q <= 1'b0;
      plus_q <= 1'b0;
    end else if (accept) begin
      list_q <= cmd_list_i;
      lvld_q <= cmd_lvld_i;
      chain_q <= cmd_chain_i;
      sync_q <= sync_mode_i;
      plus_q <= (cmd_op_i == TLR_OP_READ_PLUS1);
    end
  end

  // address and residual count
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      addr_q <= '0;
      left_q <= '0;
    end else if (accept) begin
      addr_q <= cmd_addr_i;
      left_q <= cmd_len_i;
    end else if (store && !stop_ev) begin
      addr_q <= addr_q + AW'(1);
      left_q <= left_q - CW'(1);
    end
  end

  // storage write port, registered
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_en_o <= 1'b0;
      wr_addr_o <= '0;
      wr_data_o <= '0;
    end else begin
      wr_en_o <= store && !stop_ev;
      wr_addr_o <= addr_q;
      wr_data_o <= rx_char_i;
    end
  end

  // completion status into the line control block
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      done_o <= 1'b0;
      chain_next_o <= 1'b0;
      lcb_b2_o <= TLR_ZERO_BYTE;
      lcb_b3_o <= TLR_ZERO_BYTE;
      lcb_b10_o <= TLR_ZERO_BYTE;
      lcb_b11_o <= TLR_ZERO_BYTE;
    end else begin
      done_o <= 1'b0;
      chain_next_o <= 1'b0;
      if (reject) begin
        done_o <= 1'b1;
        lcb_b2_o <= TLR_B2_REJECT;
        lcb_b3_o <= !op_ok || !list_ok ? TLR_B3_BAD_CMD :
                    !tmr_ok ? TLR_B3_BAD_TIMER : TLR_B3_ZERO_CNT;
        lcb_b10_o <= TLR_ZERO_BYTE;
        lcb_b11_o <= TLR_ZERO_BYTE;
      end else if (stop_ev) begin
        done_o <= 1'b1;
        lcb_b2_o <= TLR_B2_DONE;
        lcb_b3_o <= TLR_ZERO_BYTE;
        lcb_b10_o <= abort_i ? TLR_B10_ABORT : timeout_i ? TLR_B10_TIMER :
                     err_i[TLR_E_BCC] ? TLR_B10_BCC : err_i[TLR_E_SWO] ? TLR_B10_SW_OVR :
                     err_i[TLR_E_TXE] ? TLR_B10_TX_ERR : TLR_ZERO_BYTE;
        lcb_b11_o <= (abort_i || timeout_i || (|err_i[TLR_E_TXE:TLR_E_BCC])) ? TLR_ZERO_BYTE :
                     err_i[TLR_E_MDM] ? TLR_B11_MODEM : err_i[TLR_E_DSC] ? TLR_B11_DISC :
                     err_i[TLR_E_HWO] ? TLR_B11_HW_OVR : TLR_B11_HW_TIMER;
      end else if ((state_q == TLR_RECV && term_hit && !plus_q) ||
                   (state_q == TLR_PLUS && rx_valid_i && !strip)) begin
        done_o <= 1'b1; // no chaining after a terminator
        lcb_b2_o <= TLR_B2_DONE;
        lcb_b3_o <= TLR_ZERO_BYTE;
        lcb_b10_o <= TLR_B10_TERM;
        lcb_b11_o <= TLR_ZERO_BYTE;
      end else if (full_end) begin
        done_o <= 1'b1;
        chain_next_o <= chain_q;
        lcb_b2_o <= TLR_B2_DONE;
        lcb_b3_o <= TLR_ZERO_BYTE;
        lcb_b10_o <= TLR_ZERO_BYTE;
        lcb_b11_o <= TLR_ZERO_BYTE;
      end
    end
  end

  assign busy_o = (state_q != TLR_IDLE);
  assign residual_o = left_q;

  // checks
  property p_term_no_chain;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (term_hit && !plus_q && !stop_ev) |=> done_o && !chain_next_o && lcb_b10_o == TLR_B10_TERM;
  endproperty
  a_term_no_chain: assert property (p_term_no_chain) else $error("terminator end wrong");
  property p_plus_one;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (state_q == TLR_PLUS && rx_valid_i && !strip && !stop_ev && left_q != '0) |=>
        wr_en_o && !busy_o;
  endproperty
  a_plus_one: assert property (p_plus_one) else $error("plus-one char not stored");
  property p_pad_strip;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (strip && rx_valid_i && !stop_ev) |=> !wr_en_o && busy_o;
  endproperty
  a_pad_strip: assert property (p_pad_strip) else $error("pad stored after terminator");
  property p_full_chain;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (full_end && !stop_ev) |=> done_o && chain_next_o == chain_q && residual_o == '0;
  endproperty
  a_full_chain: assert property (p_full_chain) else $error("full buffer end wrong");
  property p_reject;
    @(posedge mclk_i) disable iff (sys_rst_i)
      reject |=> done_o && lcb_b2_o == TLR_B2_REJECT && !busy_o;
  endproperty
  a_reject: assert property (p_reject) else $error("reject status wrong");
  property p_addr_step;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (store && !stop_ev) |=> wr_en_o && addr_q == $past(addr_q) + AW'(1);
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("address not sequential");
  property p_done_b2;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (done_o && lcb_b3_o == TLR_ZERO_BYTE) |-> lcb_b2_o == TLR_B2_DONE;
  endproperty
  a_done_b2: assert property (p_done_b2) else $error("byte 2 not 80");
  c_term: cover property (@(posedge mclk_i) disable iff (sys_rst_i) term_hit);
  c_full: cover property (@(posedge mclk_i) disable iff (sys_rst_i) full_end);
  c_rej:  cover property (@(posedge mclk_i) disable iff (sys_rst_i) reject);
  c_strip: cover property (@(posedge mclk_i) disable iff (sys_rst_i) strip && rx_valid_i);
endmodule

// ### verification/tlr_line_model.sv
`timescale 1ns/1ps
// remote terminal: one character per call, optional idle gap after it
module tlr_line_model (
  input  wire logic       mclk_i,     // bench clock
  output logic            rx_valid_o, // character strobe
  output logic [7:0]      rx_char_o,  // character value
  output logic            rx_ctrl_o   // control class flag
);
  initial begin
    rx_valid_o = 1'b0;
    rx_char_o  = 8'hA5;
    rx_ctrl_o  = 1'b0;
  end
  // idle shows the inverse so a stale character never looks valid
  task automatic send(input logic [7:0] c, input logic ctl, input int gap);
    @(posedge mclk_i);
    rx_valid_o <= 1'b1;
    rx_char_o  <= c;
    rx_ctrl_o  <= ctl;
    @(posedge mclk_i);
    rx_valid_o <= 1'b0;
    rx_char_o  <= ~c;
    rx_ctrl_o  <= ~ctl;
    repeat (gap) @(posedge mclk_i);
  endtask
endmodule

// ### verification/terminated_line_receive_tb_top.sv
`timescale 1ns/1ps
module terminated_line_receive_tb_top;
  import tlr_pkg::*;
  logic        mclk_i, sys_rst_i, cmd_valid_i, cmd_chain_i, sync_mode_i;
  logic        rx_valid_i, rx_ctrl_i, abort_i, timeout_i, chain_seen;
  logic        busy_o, wr_en_o, done_o, chain_next_o;
  logic [3:0]  cmd_op_i, cmd_timer_i, cmd_lvld_i;
  logic [15:0] cmd_addr_i, cmd_len_i, residual_o, wr_addr_o;
  logic [31:0] cmd_list_i;
  logic [7:0]  pad_char_i, rx_char_i, wr_data_o, lcb_b2_o, lcb_b3_o, lcb_b10_o, lcb_b11_o;
  logic [6:0]  err_i;
  logic [23:0] wq[$];
  int          fail_count, checked, done_cnt;

  tlr_receive tlr_receive_inst (.mclk_i, .sys_rst_i, .cmd_valid_i, .cmd_op_i, .cmd_addr_i,
    .cmd_len_i, .cmd_list_i, .cmd_lvld_i, .cmd_timer_i, .cmd_chain_i, .sync_mode_i,
    .pad_char_i, .rx_valid_i, .rx_char_i, .rx_ctrl_i, .abort_i, .timeout_i, .err_i,
    .busy_o, .wr_en_o, .wr_addr_o, .wr_data_o, .done_o, .chain_next_o, .lcb_b2_o,
    .lcb_b3_o, .lcb_b10_o, .lcb_b11_o, .residual_o);
  tlr_line_model tlr_line_model_inst (.mclk_i(mclk_i), .rx_valid_o(rx_valid_i),
    .rx_char_o(rx_char_i), .rx_ctrl_o(rx_ctrl_i));

  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  // storage writes and completions, sampled before the edge updates land
  always @(posedge mclk_i) begin
    if (wr_en_o === 1'b1) wq.push_back({wr_addr_o, wr_data_o});
    if (done_o === 1'b1) begin
      done_cnt++;
      chain_seen = chain_next_o;
    end
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_stat(input logic [7:0] b3, b10, b11, input logic ch);
    chk("lcb_b2", 16'(b3 == 8'h00 ? 8'h80 : 8'hC0), 16'(lcb_b2_o));
    chk("lcb_b3", 16'(b3), 16'(lcb_b3_o));
    chk("lcb_b10", 16'(b10), 16'(lcb_b10_o));
    chk("lcb_b11", 16'(b11), 16'(lcb_b11_o));
    chk("chain_next", 16'(ch), 16'(chain_seen));
  endtask
  task automatic chk_writes(input logic [7:0] exp[$]);
    chk("write_count", 16'(exp.size()), 16'(wq.size()));
    foreach (exp[i]) if (i < wq.size()) begin
      chk("write_addr", cmd_addr_i + 16'(i), wq[i][23:8]);
      chk("write_data", 16'(exp[i]), 16'(wq[i][7:0]));
    end
  endtask
  task automatic start(input logic [3:0] op, input logic [15:0] len, input logic [3:0] lv,
                       input logic [3:0] tmr, input logic ch);
    wq.delete();
    done_cnt = 0;
    @(posedge mclk_i);
    cmd_valid_i <= 1'b1;
    cmd_op_i    <= op;
    cmd_len_i   <= len;
    cmd_lvld_i  <= lv;
    cmd_timer_i <= tmr;
    cmd_chain_i <= ch;
    @(posedge mclk_i);
    cmd_valid_i <= 1'b0;
  endtask
  // bounded wait; a missing completion ends the run
  task automatic wait_done();
    for (int n = 0; n < 64 && done_cnt == 0; n++) @(posedge mclk_i);
    @(negedge mclk_i);
    if (done_cnt == 0) begin
      fail_count++;
      $display("[FAIL] done_o expected 1 seen 0");
      finish_test();
    end
  endtask

  // entries 03 and 26 live; data 03 and control 0D of unused entry 2 pass through;
  // length 8 leaves spare room, no error status bytes are inserted here
  task automatic sc_term();
    start(TLR_OP_READ_UNTIL, 16'h0008, 4'h3, 4'h0, 1'b1);
    tlr_line_model_inst.send(8'h41, 1'b0, 0);
    tlr_line_model_inst.send(8'h03, 1'b0, 0);
    tlr_line_model_inst.send(8'h0D, 1'b1, 0);
    tlr_line_model_inst.send(8'h26, 1'b1, 0);
    wait_done();
    chk_writes('{8'h41, 8'h03, 8'h0D, 8'h26});
    chk_stat(8'h00, 8'h20, 8'h00, 1'b0);
    chk("residual", 16'h0004, residual_o);
  endtask
  // sync line: a pad after the terminator is dropped and does not count as
  // the trailing character; no completion until that character arrives
  task automatic sc_plus();
    sync_mode_i <= 1'b1;
    start(TLR_OP_READ_PLUS1, 16'h0008, 4'hF, 4'h9, 1'b1);
    tlr_line_model_inst.send(8'h42, 1'b0, 2);
    tlr_line_model_inst.send(8'h18, 1'b1, 4);
    tlr_line_model_inst.send(8'h32, 1'b0, 2);
    @(negedge mclk_i);
    chk("early_done", 16'h0000, 16'(done_cnt));
    chk("busy_plus", 16'h0001, 16'(busy_o));
    tlr_line_model_inst.send(8'h43, 1'b0, 0);
    wait_done();
    chk_writes('{8'h42, 8'h18, 8'h43});
    chk_stat(8'h00, 8'h20, 8'h00, 1'b0);
  endtask
  // full buffer in sync mode keeps pads; idle characters are dropped
  task automatic sc_full();
    sync_mode_i <= 1'b1;
    start(TLR_OP_READ_UNTIL, 16'h0003, 4'h1, 4'h0, 1'b1);
    tlr_line_model_inst.send(8'h32, 1'b0, 0);
    tlr_line_model_inst.send(8'h44, 1'b0, 0);
    tlr_line_model_inst.send(8'h32, 1'b0, 0);
    wait_done();
    chk_stat(8'h00, 8'h00, 8'h00, 1'b1);
    chk("residual_full", 16'h0000, residual_o);
    tlr_line_model_inst.send(8'h46, 1'b0, 2);
    chk_writes('{8'h32, 8'h44, 8'h32});
    sync_mode_i <= 1'b0;
  endtask
  // every stop cause: abort, timer, then each line error bit
  task automatic sc_stop();
    logic [7:0] e10[9] = '{8'h80, 8'h40, 8'h08, 8'h04, 8'h02, 0, 0, 0, 0};
    logic [7:0] e11[9] = '{0, 0, 0, 0, 0, 8'h80, 8'h40, 8'h04, 8'h02};
    for (int k = 0; k < 9; k++) begin
      start(TLR_OP_READ_UNTIL, 16'h0008, 4'h1, 4'h0, 1'b0);
      tlr_line_model_inst.send(8'h45, 1'b0, 0);
      abort_i   <= (k == 0);
      timeout_i <= (k == 1);
      err_i     <= (k > 1) ? 7'(1 << (k - 2)) : 7'h00;
      @(posedge mclk_i);
      abort_i   <= 1'b0;
      timeout_i <= 1'b0;
      err_i     <= 7'h00;
      wait_done();
      chk_stat(8'h00, e10[k], e11[k], 1'b0);
      chk_writes('{8'h45});
    end
  endtask
  // bad opcode, bad timer, zero count, empty terminator list
  task automatic sc_reject();
    logic [3:0]  op[4] = '{4'h3, 4'h1, 4'h1, 4'h1};
    logic [3:0]  tm[4] = '{4'h0, 4'hA, 4'h0, 4'h0};
    logic [15:0] ln[4] = '{16'h0008, 16'h0008, 16'h0000, 16'h0008};
    logic [3:0]  lv[4] = '{4'h1, 4'h1, 4'h1, 4'h0};
    logic [7:0]  b3[4] = '{8'hC2, 8'hC6, 8'hC4, 8'hC2};
    for (int k = 0; k < 4; k++) begin
      start(op[k], ln[k], lv[k], tm[k], 1'b0);
      wait_done();
      chk_stat(b3[k], 8'h00, 8'h00, 1'b0);
      chk("write_count", 16'h0000, 16'(wq.size()));
    end
  endtask

  initial begin
    sys_rst_i   = 1'b1;
    cmd_valid_i = 1'b0;
    cmd_op_i    = 4'h0;
    cmd_addr_i  = 16'h0100;
    cmd_len_i   = 16'h0000;
    cmd_list_i  = 32'h180D_2603;
    cmd_lvld_i  = 4'h0;
    cmd_timer_i = 4'h0;
    cmd_chain_i = 1'b0;
    sync_mode_i = 1'b0;
    pad_char_i  = 8'h32;
    abort_i     = 1'b0;
    timeout_i   = 1'b0;
    err_i       = 7'h00;
    repeat (4) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(negedge mclk_i);
    chk("reset_busy", 16'h0000, 16'(busy_o));
    chk("reset_b2", 16'h0000, 16'(lcb_b2_o));
    sc_term();
    sc_plus();
    sc_full();
    sc_stop();
    sc_reject();
    finish_test();
  end
endmodule
